// file: hdl/srp_device.sv
/*
  Register port device: serial slave with the frequency status, input
  activity status, oscillator trim, report select and alarm pin registers.
  Assumes link pins and readoutEdgeSelect arrive asynchronously to mclk;
  loop and activity inputs come from logic on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module srp_device (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // serial link
  srp_if.device            link,
  // readout edge strap pin
  input  wire logic        readoutEdgeSelect,
  // loop and input status
  input  wire logic [18:0] mainLoopFreq,
  input  wire logic [18:0] auxLoopFreq,
  input  wire logic [1:0]  noActivity,
  input  wire logic        selectedInput,
  // alarm pin
  output logic             alarmPinOut,
  output logic             alarmPinOe,
  // configuration to the loops
  output logic [15:0]      oscTrim,
  output logic             reportAux
);

  // ----------------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------------
  logic sclkMeta;
  logic sclkSync;
  logic sclkPrev;
  logic csMeta;
  logic csSync;
  logic dinMeta;
  logic dinSync;
  logic edgeMeta;
  logic edgeSync;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclkMeta <= 1'b0;
      sclkSync <= 1'b0;
      sclkPrev <= 1'b0;
      csMeta   <= 1'b1;
      csSync   <= 1'b1;
      dinMeta  <= 1'b0;
      dinSync  <= 1'b0;
      edgeMeta <= 1'b0;
      edgeSync <= 1'b0;
    end else begin
      sclkMeta <= link.sclk;
      sclkSync <= sclkMeta;
      sclkPrev <= sclkSync;
      csMeta   <= link.chipSelectN;
      csSync   <= csMeta;
      dinMeta  <= link.serialIn;
      dinSync  <= dinMeta;
      edgeMeta <= readoutEdgeSelect;
      edgeSync <= edgeMeta;
    end
  end

  // edges count only inside an access; a parked clock is harmless
  wire sclkRise = sclkSync & ~sclkPrev & ~csSync;
  wire sclkFall = ~sclkSync & sclkPrev & ~csSync;

  // ----------------------------------------------------------------------
  // frame receiver
  // ----------------------------------------------------------------------
  logic [4:0]  rxCount;
  logic [15:0] rxShift;

  // first bit received lands in bit 0
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxCount <= 5'h00;
      rxShift <= 16'h0000;
    end else if (csSync) begin
      rxCount <= 5'h00;
    end else if (sclkRise && rxCount != srp_pkg::FRAME_BITS) begin
      rxShift[rxCount[3:0]] <= dinSync;
      rxCount               <= rxCount + 5'h01;
    end
  end

  wire [6:0] frameAddr = rxShift[srp_pkg::ADDR_BITS-1:0];
  wire [7:0] frameData = {dinSync, rxShift[14:8]};
  wire readNow  = sclkRise && rxCount == srp_pkg::RW_INDEX && dinSync;
  wire writeNow = sclkRise && rxCount == srp_pkg::LAST_INDEX
                  && !rxShift[srp_pkg::RW_INDEX[3:0]];
  wire accessNow = readNow | writeNow;

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  logic [7:0] trimStage;
  logic       trimArmed;
  logic [1:0] alarmCfg;

  wire hitTrimLow  = frameAddr == srp_pkg::ADDR_TRIM_LOW;
  wire hitTrimHigh = frameAddr == srp_pkg::ADDR_TRIM_HIGH;
  wire hitReport   = frameAddr == srp_pkg::ADDR_REPORT;
  wire hitAlarm    = frameAddr == srp_pkg::ADDR_ALARM;

  // low byte is staged; the pair commits only if the high byte is the very
  // next access, anything else in between throws the staged byte away
  wire stageTrim  = writeNow && hitTrimLow;
  wire commitTrim = writeNow && hitTrimHigh && trimArmed;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trimStage <= srp_pkg::TRIM_RESET;
      trimArmed <= 1'b0;
    end else if (accessNow) begin
      trimArmed <= stageTrim;
      if (stageTrim) begin
        trimStage <= frameData;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      oscTrim <= {srp_pkg::TRIM_RESET, srp_pkg::TRIM_RESET};
    end else if (commitTrim) begin
      oscTrim <= {frameData, trimStage};
    end
  end

  // only the defined bits are stored; other positions are ignored
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reportAux <= srp_pkg::REPORT_RESET[srp_pkg::REPORT_AUX_BIT];
      alarmCfg  <= {srp_pkg::ALARM_RESET[srp_pkg::ALARM_DRIVE_BIT],
                    srp_pkg::ALARM_RESET[srp_pkg::ALARM_POL_BIT]};
    end else if (writeNow) begin
      if (hitReport) begin
        reportAux <= frameData[srp_pkg::REPORT_AUX_BIT];
      end
      if (hitAlarm) begin
        alarmCfg <= {frameData[srp_pkg::ALARM_DRIVE_BIT],
                     frameData[srp_pkg::ALARM_POL_BIT]};
      end
    end
  end

  // ----------------------------------------------------------------------
  // frequency status with freeze
  // ----------------------------------------------------------------------
  logic [18:0] freqShadow;
  logic [2:0]  freezeMask;

  wire [18:0] freqLive = reportAux ? auxLoopFreq : mainLoopFreq;
  wire hitFreqLow = frameAddr == srp_pkg::ADDR_FREQ_LOW;
  wire hitFreqMid = frameAddr == srp_pkg::ADDR_FREQ_MID;
  wire hitFreqTop = frameAddr == srp_pkg::ADDR_FREQ_TOP;
  wire [2:0] freqHit  = {hitFreqTop, hitFreqMid, hitFreqLow};
  wire       freqRead = readNow && freqHit != 3'h0;
  wire [2:0] maskNext = freezeMask | freqHit;
  wire [18:0] freqView = (freezeMask != 3'h0) ? freqShadow : freqLive;

  // first byte read snapshots all three; released once each byte was read
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      freqShadow <= 19'h00000;
      freezeMask <= 3'h0;
    end else if (freqRead) begin
      if (freezeMask == 3'h0) begin
        freqShadow <= freqLive;
      end
      freezeMask <= (maskNext == 3'h7) ? 3'h0 : maskNext;
    end
  end

  // ----------------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------------
  logic [7:0] readMux;
  wire  [7:0] activityByte = {2'h0, noActivity[1], 3'h0, noActivity[0],
                              1'h0};

  always_comb begin
    if (hitFreqLow) begin
      readMux = freqView[7:0];
    end else if (hitFreqMid) begin
      readMux = freqView[15:8];
    end else if (hitFreqTop) begin
      readMux = {5'h00, freqView[18:16]};
    end else if (frameAddr == srp_pkg::ADDR_ACTIVITY) begin
      readMux = activityByte;
    end else if (hitTrimLow) begin
      readMux = oscTrim[7:0];
    end else if (hitTrimHigh) begin
      readMux = oscTrim[15:8];
    end else if (hitReport) begin
      readMux = {3'h0, reportAux, 4'h0};
    end else if (hitAlarm) begin
      readMux = {6'h00, alarmCfg};
    end else begin
      readMux = 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------------
  logic [7:0] readData;

  // the byte is latched whole when the read is recognised, so it is the
  // shadow copy that shifts out, not the live value
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      readData <= 8'h00;
    end else if (readNow) begin
      readData <= readMux;
    end
  end

  wire inData   = rxCount >= srp_pkg::DATA_FIRST
                  && rxCount <= srp_pkg::LAST_INDEX;
  wire shiftOut = link.serialOutOe && inData
                  && ((sclkRise && !edgeSync) || (sclkFall && edgeSync));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      link.serialOut   <= 1'b0;
      link.serialOutOe <= 1'b0;
    end else if (csSync) begin
      link.serialOutOe <= 1'b0;
    end else begin
      if (readNow) begin
        link.serialOutOe <= 1'b1;
      end
      if (shiftOut) begin
        link.serialOut <= readData[rxCount[2:0]];
      end
    end
  end

  // ----------------------------------------------------------------------
  // alarm pin
  // ----------------------------------------------------------------------
  wire alarmActive = noActivity[selectedInput];
  wire alarmLevel  = alarmCfg[0] ? alarmActive : ~alarmActive;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarmPinOut <= 1'b1;
      alarmPinOe  <= 1'b0;
    end else begin
      alarmPinOut <= alarmLevel;
      alarmPinOe  <= alarmActive | alarmCfg[1];
    end
  end

endmodule
`default_nettype wire

// file: hdl/srp_pkg.sv
/*
  Constants shared by both ends of the serial register port: register
  addresses, reset values, field positions, frame layout, link timing and
  the host controller's own register map.
  Assumes a 25 MHz mclk on both ends and 32-bit APB on the host side.
*/
`default_nettype none
package srp_pkg;

  // ----------------------------------------------------------------------
  // device register addresses
  // ----------------------------------------------------------------------
  localparam logic [6:0] ADDR_FREQ_TOP  = 7'h07;
  localparam logic [6:0] ADDR_FREQ_LOW  = 7'h0C;
  localparam logic [6:0] ADDR_FREQ_MID  = 7'h0D;
  localparam logic [6:0] ADDR_ACTIVITY  = 7'h11;
  localparam logic [6:0] ADDR_TRIM_LOW  = 7'h3C;
  localparam logic [6:0] ADDR_TRIM_HIGH = 7'h3D;
  localparam logic [6:0] ADDR_REPORT    = 7'h4B;
  localparam logic [6:0] ADDR_ALARM     = 7'h7D;

  // ----------------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------------
  localparam logic [7:0] TRIM_RESET      = 8'h99;
  localparam logic [7:0] REPORT_RESET    = 8'h00;
  localparam logic [7:0] ALARM_RESET     = 8'h00;
  localparam int         REPORT_AUX_BIT  = 4;
  localparam int         ALARM_POL_BIT   = 0;
  localparam int         ALARM_DRIVE_BIT = 1;
  localparam int         ACT_IN1_BIT     = 1;
  localparam int         ACT_IN2_BIT     = 5;
  localparam int         FREQ_BITS       = 19;

  // ----------------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------------
  localparam int         ADDR_BITS  = 7;
  localparam logic [4:0] RW_INDEX   = 5'h07;
  localparam logic [4:0] DATA_FIRST = 5'h08;
  localparam logic [4:0] LAST_INDEX = 5'h0F;
  localparam logic [4:0] FRAME_BITS = 5'h10;

  // ----------------------------------------------------------------------
  // host link timing
  // ----------------------------------------------------------------------
  localparam int         MCLK_NS     = 40;
  localparam int         SCLK_HALF_NS = 320;
  localparam int         GAP_NS      = 320;
  localparam logic [3:0] HALF_CYCLES =
    4'((SCLK_HALF_NS + MCLK_NS - 1) / MCLK_NS);
  localparam logic [3:0] GAP_CYCLES  =
    4'((GAP_NS + MCLK_NS - 1) / MCLK_NS);

  // ----------------------------------------------------------------------
  // host controller registers on APB
  // ----------------------------------------------------------------------
  localparam logic [11:0] HOST_CMD      = 12'h000;
  localparam logic [11:0] HOST_STATUS   = 12'h004;
  localparam logic [11:0] HOST_CFG      = 12'h008;
  localparam int          CMD_RW_BIT    = 7;
  localparam int          CMD_WDATA_LSB = 8;
  localparam int          CMD_START_BIT = 16;
  localparam int          STAT_BUSY_BIT = 8;
  localparam int          STAT_DONE_BIT = 9;

endpackage
`default_nettype wire

// file: hdl/srp_if.sv
/*
  Serial link between the host controller and the register port device.
  serialOut carries meaning only while serialOutOe is high; the host reads
  it only in the data half of a read frame.
*/
`timescale 1ns/1ps
`default_nettype none
interface srp_if;
  logic sclk;
  logic chipSelectN;
  logic serialIn;
  logic serialOut;
  logic serialOutOe;

  modport device (
    input  sclk,
    input  chipSelectN,
    input  serialIn,
    output serialOut,
    output serialOutOe
  );

  modport host (
    output sclk,
    output chipSelectN,
    output serialIn,
    input  serialOut,
    input  serialOutOe
  );
endinterface
`default_nettype wire

// file: hdl/srp_host.sv
/*
  Host controller: runs one serial access at a time on behalf of software,
  which gives orders and reads results over APB.
  Assumes the device drives serial data within a few mclk of each edge.
*/
`timescale 1ns/1ps
`default_nettype none
module srp_host (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // serial link
  srp_if.host              link
);

  typedef enum logic [1:0] {IDLE, SHIFT, GAP} srp_host_state_t;

  srp_host_state_t state;
  logic [3:0]  divCount;
  logic [3:0]  bitIdx;
  logic [15:0] frame;
  logic [7:0]  rdShift;
  logic        captureOnRise;
  logic        done;
  logic        readMeta;
  logic        readSync;

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  wire access   = psel & penable;
  wire commit   = access & pready;
  wire hitCmd   = paddr == srp_pkg::HOST_CMD;
  wire hitStat  = paddr == srp_pkg::HOST_STATUS;
  wire hitCfg   = paddr == srp_pkg::HOST_CFG;
  wire mapped   = hitCmd | hitStat | hitCfg;
  wire busy     = state != IDLE;
  wire start    = commit && pwrite && hitCmd && !busy
                  && pwdata[srp_pkg::CMD_START_BIT];
  wire [31:0] rdValue = hitStat ? {22'h0, done, busy, rdShift}
                      : hitCfg ? {31'h0, captureOnRise}
                      : hitCmd ? {16'h0, frame} : 32'h0;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      prdata  <= rdValue;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      captureOnRise <= 1'b0;
    end else if (commit && pwrite && hitCfg) begin
      captureOnRise <= pwdata[0];
    end
  end

  // ----------------------------------------------------------------------
  // link engine
  // ----------------------------------------------------------------------
  wire lastDiv  = divCount == 4'(2 * srp_pkg::HALF_CYCLES - 1);
  wire riseDiv  = divCount == srp_pkg::HALF_CYCLES - 4'h1;
  wire sampleAt = captureOnRise ? riseDiv : lastDiv;
  wire finish   = state == GAP && divCount == srp_pkg::GAP_CYCLES;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      readMeta <= 1'b0;
      readSync <= 1'b0;
    end else begin
      readMeta <= link.serialOut;
      readSync <= readMeta;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else if (finish) begin
      done <= 1'b1;
    end else if (start || (commit && !pwrite && hitStat)) begin
      done <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state            <= IDLE;
      divCount         <= 4'h0;
      bitIdx           <= 4'h0;
      frame            <= 16'h0000;
      rdShift          <= 8'h00;
      link.sclk        <= 1'b0;
      link.chipSelectN <= 1'b1;
      link.serialIn    <= 1'b0;
    end else begin
      case (state)
        IDLE: begin
          if (start) begin
            frame            <= pwdata[15:0];
            link.chipSelectN <= 1'b0;
            link.serialIn    <= pwdata[0];
            divCount         <= 4'h0;
            bitIdx           <= 4'h0;
            state            <= SHIFT;
          end
        end
        SHIFT: begin
          divCount <= divCount + 4'h1;
          if (riseDiv) begin
            link.sclk <= 1'b1;
          end
          if (sampleAt && bitIdx >= 4'h8 && frame[srp_pkg::CMD_RW_BIT]) begin
            rdShift[bitIdx[2:0]] <= readSync;
          end
          if (lastDiv) begin
            link.sclk <= 1'b0;
            if (bitIdx == 4'hF) begin
              link.chipSelectN <= 1'b1;
              divCount         <= 4'h0;
              state            <= GAP;
            end else begin
              bitIdx        <= bitIdx + 4'h1;
              link.serialIn <= frame[bitIdx + 4'h1];
            end
          end
        end
        GAP: begin
          divCount <= divCount + 4'h1;
          if (finish) begin
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// file: verif/srp_props.sv
/*
  Checker on the serial link between host and device.
  Assumes both ends and this checker share mclk and rst_n.
*/
`timescale 1ns/1ps
`default_nettype none
module srp_props (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // serial link
  input wire logic sclk,
  input wire logic chipSelectN,
  input wire logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutOe
);
  // ----------------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------------
  logic       sclkQ;
  logic [4:0] rises;
  logic [3:0] age;
  wire        sclkRise = sclk & ~sclkQ;
  wire        sclkEdge = sclk ^ sclkQ;
  wire        ageTop   = age == 4'hF;

  // age saturates so long idle spans cannot wrap into a false pass
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclkQ <= 1'b0;
      rises <= 5'h00;
      age   <= 4'hF;
    end else begin
      sclkQ <= sclk;
      rises <= chipSelectN ? 5'h00 : rises + 5'(sclkRise);
      age   <= sclkEdge ? 4'h0 : age + 4'(!ageTop);
    end
  end

  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_sclk_idle; chipSelectN |-> !sclk; endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("serial clock high while deselected");
  property p_cs_gap; $rose(chipSelectN) |-> chipSelectN[*4]; endproperty
  a_cs_gap: assert property (p_cs_gap)
    else $error("frame gap too short");
  property p_lead; $fell(chipSelectN) |-> !sclk[*6]; endproperty
  a_lead: assert property (p_lead)
    else $error("serial clock rose too soon after select");
  property p_high; $rose(sclk) |-> sclk[*8] ##1 !sclk; endproperty
  a_high: assert property (p_high)
    else $error("serial clock high time wrong");
  property p_sdi_hold;
    !chipSelectN && $changed(serialIn) |-> !sclk;
  endproperty
  a_sdi_hold: assert property (p_sdi_hold)
    else $error("serial input moved while clock high");
  property p_frame_len; $rose(chipSelectN) |-> rises == 5'h10; endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame did not carry sixteen bits");
  property p_oe_start;
    $rose(serialOutOe) |-> !chipSelectN && rises == 5'h08;
  endproperty
  a_oe_start: assert property (p_oe_start)
    else $error("read drive began at wrong bit");
  property p_sdo_edge;
    serialOutOe && $past(serialOutOe) && $changed(serialOut) |-> age <= 4'h5;
  endproperty
  a_sdo_edge: assert property (p_sdo_edge)
    else $error("serial output moved away from a clock edge");
  property p_oe_release; $rose(chipSelectN) |-> ##[0:4] !serialOutOe; endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("serial output not released");

  c_read: cover property ($rose(serialOutOe));
  c_write: cover property ($rose(chipSelectN) && !serialOutOe);
  c_gap: cover property ($rose(chipSelectN) ##[4:40] $fell(chipSelectN));
endmodule
`default_nettype wire

// file: verif/tb.sv
/*
  Self-checking bench: host and device joined by the link interface,
  orders given over APB, every result compared with a model.
  Assumes a one-wait-state APB slave and the host's own clock divider.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, lastErr;
  logic        edgeSel, selIn, alOut, alOe, repAux, pend;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, v;
  logic [18:0] mainF, auxF, snapF;
  logic [15:0] trim, mTrim, frameBits;
  logic [7:0]  mRep, mAlarm, pendV;
  logic [1:0]  noAct;
  logic [2:0]  snapMask;
  logic [15:0] frameQ[$];
  logic [6:0]  rdList[6] = '{7'h3C, 7'h3D, 7'h4B, 7'h7D, 7'h11, 7'h05};
  logic [6:0]  grp[3] = '{7'h0C, 7'h0D, 7'h07};
  int          num_errors = 0;
  int          total_checks = 0;
  int          seed = 73;
  wire         alarmLine = alOe ? alOut : 1'b1;  // board pull-up

  srp_if link ();
  srp_device srp_device_inst (
    .mclk(mclk), .rst_n(rst_n), .link(link.device),
    .readoutEdgeSelect(edgeSel), .mainLoopFreq(mainF), .auxLoopFreq(auxF),
    .noActivity(noAct), .selectedInput(selIn), .alarmPinOut(alOut),
    .alarmPinOe(alOe), .oscTrim(trim), .reportAux(repAux));
  srp_host srp_host_inst (
    .mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link.host));
  srp_props srp_props_inst (
    .mclk(mclk), .rst_n(rst_n), .sclk(link.sclk),
    .chipSelectN(link.chipSelectN), .serialIn(link.serialIn),
    .serialOut(link.serialOut), .serialOutOe(link.serialOutOe));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ----------------------------------------------------------------------
  // compare, bus and model tasks
  // ----------------------------------------------------------------------
  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // read frames carry host filler in the data half, so only the head counts
  task automatic chkWire(input logic [15:0] got, input logic [15:0] exp);
    chkVal(exp[7] ? got[7:0] : got, exp[7] ? exp[7:0] : exp);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic acc(input logic [6:0] a, input logic r, input logic [7:0] wd);
    logic [31:0] s;
    logic [7:0]  e, m;
    frameQ.push_back({wd, r, a});
    apb(12'h000, 1'b1, {15'h0, 1'b1, wd, r, a}, s);
    s = '0;
    while (s[9] !== 1'b1) apb(12'h004, 1'b0, 32'h0, s);
    chkVal(s[8], 1'b0);
    m = a == 7'h4B ? 8'h10 : a == 7'h7D ? 8'h03 : a == 7'h07 ? 8'h07 : 8'hFF;
    if (r) begin
      if (a inside {7'h07, 7'h0C, 7'h0D}) begin
        if (snapMask == 3'h0) snapF = mRep[4] ? auxF : mainF;
        snapMask[a == 7'h07 ? 0 : a == 7'h0C ? 1 : 2] = 1'b1;
      end
      case (a)
        7'h07: e = {5'h0, snapF[18:16]};
        7'h0C: e = snapF[7:0];
        7'h0D: e = snapF[15:8];
        7'h11: e = {2'h0, noAct[1], 3'h0, noAct[0], 1'b0};
        7'h3C: e = mTrim[7:0];
        7'h3D: e = mTrim[15:8];
        7'h4B: e = mRep;
        7'h7D: e = mAlarm;
        default: e = 8'h00;
      endcase
      if (snapMask == 3'h7) snapMask = 3'h0;
      chkVal(s[7:0] & m, e & m);
    end else if (a == 7'h4B) mRep = wd;
    else if (a == 7'h7D) mAlarm = wd;
    if (!r && a == 7'h3D && pend) mTrim = {wd, pendV};
    pend = !r && a == 7'h3C;
    pendV = wd;
  endtask

  task automatic chkAlarm;
    logic on;
    repeat (3) @(posedge mclk);
    on = noAct[selIn];
    chkVal({alOe, alarmLine}, {on | mAlarm[1],
           on ? mAlarm[0] : (mAlarm[1] ? ~mAlarm[0] : 1'b1)});
  endtask

  task automatic doReset;
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    {mRep, mAlarm, pend, snapMask} = '0;
    mTrim = 16'h9999;
    @(posedge mclk);
    chkVal({repAux, trim}, {1'b0, mTrim});
  endtask

  always @(posedge link.sclk) begin
    if (!link.chipSelectN) frameBits <= {link.serialIn, frameBits[15:1]};
  end
  always @(posedge link.chipSelectN) begin
    if (frameQ.size() > 0) chkWire(frameBits, frameQ.pop_front());
  end

  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    $display("watchdog expired at %0t", $time);
    results;
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {edgeSel, selIn, noAct, mainF, auxF} = '0;
    rst_n = 1'b0;
    doReset;
    foreach (rdList[i]) acc(rdList[i], 1'b1, 8'h00);
    acc(7'h11, 1'b0, 8'hFF);
    acc(7'h0C, 1'b0, 8'h5A);
    acc(7'h11, 1'b1, 8'h00);
    apb(12'hFFC, 1'b0, 32'h0, q);
    chkVal(lastErr, 1'b1);
    apb(12'h000, 1'b0, 32'h0, q);
    chkVal(lastErr, 1'b0);
    chkVal(q, 32'h00000091);
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      v = $random(seed);
      if (i != 2) acc(7'h3C, 1'b0, v[7:0]);
      if (i == 1) acc(7'h4B, 1'b0, 8'h00);
      acc(7'h3D, 1'b0, v[15:8]);
      chkVal(trim, mTrim);
      acc(7'h3C, 1'b1, 8'h00);
      acc(7'h3D, 1'b1, 8'h00);
    end
    $display("test trim pair done");
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      acc(7'h4B, 1'b0, {v[7:5], i[0], v[3:0]});
      chkVal(repAux, i[0]);
      for (int k = 0; k < 3; k++) begin
        v = $random(seed);
        mainF <= v[18:0];
        auxF <= v[31:13];
        acc(grp[(i + k) % 3], 1'b1, 8'h00);
      end
    end
    $display("test frequency status done");
    for (int i = 0; i < 16; i++) begin
      if (i % 4 == 0) acc(7'h7D, 1'b0, 8'(i / 4));
      v = $random(seed);
      noAct <= v[1:0];
      selIn <= v[2];
      chkAlarm;
    end
    $display("test alarm pin done");
    edgeSel <= 1'b1;
    apb(12'h008, 1'b1, 32'h1, q);
    apb(12'h008, 1'b0, 32'h0, q);
    chkVal(q, 32'h00000001);
    foreach (rdList[i]) acc(rdList[i], 1'b1, 8'h00);
    foreach (grp[i]) acc(grp[i], 1'b1, 8'h00);
    edgeSel <= 1'b0;
    apb(12'h008, 1'b1, 32'h0, q);
    $display("test falling readout done");
    acc(7'h4B, 1'b0, 8'h10);
    acc(7'h7D, 1'b0, 8'h03);
    doReset;
    chkAlarm;
    acc(7'h7D, 1'b1, 8'h00);
    $display("test second reset done");
    results;
  end
endmodule
`default_nettype wire
